//--- rtl/apt_timer.sv
// Top of the auxiliary period timer with its register slave.
//
// Contract
// - Timer mode: prescaled module clock, optional /256.
// - Select n divides by 2^n, times 256 when pre is set.
// - Prescaler held cleared while run is 0.
// - Counter mode: soft strobe, rising or falling edge.
// - Count up; match returns to zero.
// - Zero-match active while counter equals zero.
// - Write loads shadow period; read returns active.
// - Transfer enable set/cleared by write-one strobes.
// - Run bit by set/clear strobes and hardware.
// - Single shot stops at period end.
// - Counter reset strobe clears only counter.
// - Counter writes ignored while running.
// - Selected main-timer event sets run bit.
// - Trigger event field selects main-timer event.
// - Direction field qualifies the selected event.
// - Shadow transfer when stopped, or enabled match.
// - Sixteen-bit upward counter with equality compare.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module apt_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic externalCountInput,
  input wire logic mainCountDirection,
  input wire logic mainPeriodMatch,
  input wire logic mainZeroMatch,
  input wire logic mainCompareCh0,
  input wire logic mainCompareCh1,
  input wire logic mainCompareCh2,
  input wire logic hallStateChange,
  output logic auxPeriodMatch,
  output logic auxZeroMatch,
  output logic auxShadowTransfer,
  output logic auxRunBit,
  output logic [15:0] auxCount,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rstMeta_r;
  logic rstSync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  apt_pkg::apt_state_s state_r;
  apt_pkg::apt_state_s state_nxt;

  logic wrFire;
  logic rdFire;
  logic [31:0] wrMask;
  logic [31:0] wrBits;
  logic [31:0] wrMerged;
  logic wrCtrl;
  logic wrAction;
  logic wrCount;
  logic wrPeriod;
  logic wrStatus;
  logic wrMaskReg;
  logic softCountStrobe;
  logic presTick;
  logic countEvent;
  logic trigger;
  logic countEn;
  logic periodMatch;
  logic zeroMatch;
  logic singleStop;
  logic [3:0] events;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic logic hits(input logic [5:0] addr,
                                input logic [5:0] reg_addr);
    hits = (addr[5:2] == reg_addr[5:2]);
  endfunction

  function automatic logic mapped(input logic [5:0] addr);
    mapped = hits(addr, apt_pkg::ADDR_CTRL) ||
             hits(addr, apt_pkg::ADDR_ACTION) ||
             hits(addr, apt_pkg::ADDR_COUNT) ||
             hits(addr, apt_pkg::ADDR_PERIOD) ||
             hits(addr, apt_pkg::ADDR_STATUS) ||
             hits(addr, apt_pkg::ADDR_MASK);
  endfunction

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  always_comb begin
    wrFire = s_axi_awvalid && s_axi_wvalid && !state_r.bvalid && ce;
    rdFire = s_axi_arvalid && !state_r.rvalid && ce;
    s_axi_awready = wrFire;
    s_axi_wready = wrFire;
    s_axi_arready = rdFire;
    s_axi_bvalid = state_r.bvalid;
    s_axi_bresp = state_r.bresp;
    s_axi_rvalid = state_r.rvalid;
    s_axi_rresp = state_r.rresp;
    s_axi_rdata = state_r.rdata;
  end

  generate
    for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wrMask[8*b +: 8] = {8{s_axi_wstrb[b]}};
    end
  endgenerate

  always_comb begin
    wrBits = s_axi_wdata & wrMask;
    wrCtrl = wrFire && hits(s_axi_awaddr, apt_pkg::ADDR_CTRL);
    wrAction = wrFire && hits(s_axi_awaddr, apt_pkg::ADDR_ACTION);
    wrCount = wrFire && hits(s_axi_awaddr, apt_pkg::ADDR_COUNT);
    wrPeriod = wrFire && hits(s_axi_awaddr, apt_pkg::ADDR_PERIOD);
    wrStatus = wrFire && hits(s_axi_awaddr, apt_pkg::ADDR_STATUS);
    wrMaskReg = wrFire && hits(s_axi_awaddr, apt_pkg::ADDR_MASK);
    softCountStrobe = wrAction && wrBits[apt_pkg::ACT_SOFT_CNT];
  end

  // ----------------------------------------------------------------------
  // Count clock sources
  // ----------------------------------------------------------------------
  apt_prescaler #(
    .WIDTH(apt_pkg::PRESC_W)
  ) i_apt_prescaler (
    .clk(clk),
    .rstSync_n(rstSync_n),
    .ce(ce),
    .run(state_r.run),
    .clkSel(state_r.clkSel),
    .extraDiv(state_r.pre),
    .tick(presTick)
  );

  apt_event_unit i_apt_event_unit (
    .clk(clk),
    .rstSync_n(rstSync_n),
    .ce(ce),
    .externalCountInput(externalCountInput),
    .softCountStrobe(softCountStrobe),
    .countInputSelect(state_r.isel),
    .triggerEventSelect(state_r.tec),
    .triggerDirectionSelect(state_r.ted),
    .mainCountDirection(mainCountDirection),
    .mainPeriodMatch(mainPeriodMatch),
    .mainZeroMatch(mainZeroMatch),
    .mainCompareCh0(mainCompareCh0),
    .mainCompareCh1(mainCompareCh1),
    .mainCompareCh2(mainCompareCh2),
    .hallStateChange(hallStateChange),
    .countEvent(countEvent),
    .trigger(trigger)
  );

  // ----------------------------------------------------------------------
  // Timer core and registers
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    wrMerged = 32'h0000_0000;
    countEn = state_r.run &&
      ((state_r.isel == apt_pkg::APT_ISEL_TIMER) ? presTick
                                                 : countEvent);
    periodMatch = (state_r.count == state_r.activePeriod);
    zeroMatch = (state_r.count == apt_pkg::COUNT_RST);
    auxShadowTransfer = !state_r.run ||
                        (state_r.ste && periodMatch);
    singleStop = countEn && periodMatch && state_r.sse;

    // Counter: count up and wrap on match, or software reset/load.
    if (countEn) begin
      if (periodMatch) begin
        state_nxt.count = apt_pkg::COUNT_RST;
      end else begin
        state_nxt.count = state_r.count + 16'h0001;
      end
    end
    if (wrCount && !state_r.run) begin
      wrMerged = ({16'h0000, state_r.count} & ~wrMask) | wrBits;
      state_nxt.count = wrMerged[15:0];
    end
    if (wrAction && wrBits[apt_pkg::ACT_CNT_RST]) begin
      state_nxt.count = apt_pkg::COUNT_RST;
    end

    // Period: writes reach the shadow, transfer feeds the active copy.
    if (wrPeriod) begin
      state_nxt.shadowPeriod[7:0] = s_axi_wstrb[0] ? s_axi_wdata[7:0]
                                    : state_r.shadowPeriod[7:0];
      state_nxt.shadowPeriod[15:8] = s_axi_wstrb[1] ? s_axi_wdata[15:8]
                                     : state_r.shadowPeriod[15:8];
    end
    if (!state_r.run || (countEn && auxShadowTransfer)) begin
      state_nxt.activePeriod = state_r.shadowPeriod;
      if (state_r.run) begin
        state_nxt.ste = 1'b0;
      end
    end

    if (wrAction && wrBits[apt_pkg::ACT_STE_CLR]) begin
      state_nxt.ste = 1'b0;
    end
    if (wrAction && wrBits[apt_pkg::ACT_STE_SET]) begin
      state_nxt.ste = 1'b1;
    end

    // Run bit: clears first, then sets win.
    if ((wrAction && wrBits[apt_pkg::ACT_RUN_CLR]) || singleStop) begin
      state_nxt.run = 1'b0;
    end
    if ((wrAction && wrBits[apt_pkg::ACT_RUN_SET]) || trigger) begin
      state_nxt.run = 1'b1;
    end

    if (wrCtrl && s_axi_wstrb[0]) begin
      state_nxt.clkSel = s_axi_wdata[apt_pkg::CTRL_CLKSEL_LSB +: 3];
      state_nxt.pre = s_axi_wdata[apt_pkg::CTRL_PRE_BIT];
      state_nxt.sse = s_axi_wdata[apt_pkg::CTRL_SSE_BIT];
      state_nxt.tec = s_axi_wdata[apt_pkg::CTRL_TEC_LSB +: 3];
    end
    if (wrCtrl && s_axi_wstrb[1]) begin
      state_nxt.ted = s_axi_wdata[apt_pkg::CTRL_TED_LSB +: 2];
      state_nxt.isel = s_axi_wdata[apt_pkg::CTRL_ISEL_LSB +: 2];
    end

    // Sticky status: a new event wins over a clear.
    events = '0;
    events[apt_pkg::STAT_PM] = countEn && periodMatch;
    events[apt_pkg::STAT_ZM] = countEn && (state_r.count ==
                               state_r.activePeriod);
    events[apt_pkg::STAT_TRIG] = trigger;
    events[apt_pkg::STAT_SSTOP] = singleStop;
    if (wrStatus) begin
      state_nxt.status = state_r.status & ~wrBits[3:0];
    end
    state_nxt.status = state_nxt.status | events;
    if (wrMaskReg && s_axi_wstrb[0]) begin
      state_nxt.mask = s_axi_wdata[3:0];
    end

    if (wrFire) begin
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp = mapped(s_axi_awaddr) ? apt_pkg::RESP_OKAY
                                             : apt_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      state_nxt.bvalid = 1'b0;
    end

    if (rdFire) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp = mapped(s_axi_araddr) ? apt_pkg::RESP_OKAY
                                             : apt_pkg::RESP_SLVERR;
      state_nxt.rdata = 32'h0000_0000;
      if (hits(s_axi_araddr, apt_pkg::ADDR_CTRL)) begin
        state_nxt.rdata[apt_pkg::CTRL_CLKSEL_LSB +: 3] = state_r.clkSel;
        state_nxt.rdata[apt_pkg::CTRL_PRE_BIT] = state_r.pre;
        state_nxt.rdata[apt_pkg::CTRL_SSE_BIT] = state_r.sse;
        state_nxt.rdata[apt_pkg::CTRL_TEC_LSB +: 3] = state_r.tec;
        state_nxt.rdata[apt_pkg::CTRL_TED_LSB +: 2] = state_r.ted;
        state_nxt.rdata[apt_pkg::CTRL_ISEL_LSB +: 2] = state_r.isel;
        state_nxt.rdata[apt_pkg::CTRL_RUN_BIT] = state_r.run;
        state_nxt.rdata[apt_pkg::CTRL_STE_BIT] = state_r.ste;
      end else if (hits(s_axi_araddr, apt_pkg::ADDR_COUNT)) begin
        state_nxt.rdata[15:0] = state_r.count;
      end else if (hits(s_axi_araddr, apt_pkg::ADDR_PERIOD)) begin
        state_nxt.rdata[15:0] = state_r.activePeriod;
      end else if (hits(s_axi_araddr, apt_pkg::ADDR_STATUS)) begin
        state_nxt.rdata[3:0] = state_r.status;
      end else if (hits(s_axi_araddr, apt_pkg::ADDR_MASK)) begin
        state_nxt.rdata[3:0] = state_r.mask;
      end
    end else if (s_axi_rready) begin
      state_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_r <= '{
        count: apt_pkg::COUNT_RST,
        activePeriod: apt_pkg::PERIOD_RST,
        shadowPeriod: apt_pkg::PERIOD_RST,
        mask: apt_pkg::MASK_RST,
        bresp: apt_pkg::RESP_OKAY,
        rresp: apt_pkg::RESP_OKAY,
        default: '0
      };
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_comb begin
    auxPeriodMatch = periodMatch && state_r.run;
    auxZeroMatch = zeroMatch;
    auxRunBit = state_r.run;
    auxCount = state_r.count;
    irq = |(state_r.status & state_r.mask);
  end

endmodule

//--- pkg/apt_pkg.sv
// Package with register map, field layout, reset values and types of the timer.
package apt_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_ACTION = 6'h04;
  localparam logic [5:0] ADDR_COUNT = 6'h08;
  localparam logic [5:0] ADDR_PERIOD = 6'h0c;
  localparam logic [5:0] ADDR_STATUS = 6'h10;
  localparam logic [5:0] ADDR_MASK = 6'h14;

  // ----------------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_CLKSEL_LSB = 0;
  localparam int CTRL_PRE_BIT = 3;
  localparam int CTRL_SSE_BIT = 4;
  localparam int CTRL_TEC_LSB = 5;
  localparam int CTRL_TED_LSB = 8;
  localparam int CTRL_ISEL_LSB = 10;
  localparam int CTRL_RUN_BIT = 16;
  localparam int CTRL_STE_BIT = 17;

  // ----------------------------------------------------------------------
  // Action register bits, write-only strobes
  // ----------------------------------------------------------------------
  localparam int ACT_RUN_SET = 0;
  localparam int ACT_RUN_CLR = 1;
  localparam int ACT_CNT_RST = 2;
  localparam int ACT_STE_SET = 3;
  localparam int ACT_STE_CLR = 4;
  localparam int ACT_SOFT_CNT = 5;

  // ----------------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------------
  localparam int STAT_PM = 0;
  localparam int STAT_ZM = 1;
  localparam int STAT_TRIG = 2;
  localparam int STAT_SSTOP = 3;
  localparam int STAT_W = 4;

  // ----------------------------------------------------------------------
  // Widths, reset values and counts
  // ----------------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int PRESC_W = 15;
  localparam int EXTRA_DIV_LOG2 = 8;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    APT_ISEL_TIMER = 2'h0,
    APT_ISEL_SOFT = 2'h1,
    APT_ISEL_RISE = 2'h2,
    APT_ISEL_FALL = 2'h3
  } apt_isel_e;

  typedef enum logic [2:0] {
    APT_TEC_NONE = 3'h0,
    APT_TEC_CH0 = 3'h1,
    APT_TEC_CH1 = 3'h2,
    APT_TEC_CH2 = 3'h3,
    APT_TEC_ANY = 3'h4,
    APT_TEC_PM = 3'h5,
    APT_TEC_ZMUP = 3'h6,
    APT_TEC_HALL = 3'h7
  } apt_tec_e;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] activePeriod;
    logic [15:0] shadowPeriod;
    logic run;
    logic ste;
    logic sse;
    logic pre;
    logic [2:0] clkSel;
    logic [2:0] tec;
    logic [1:0] ted;
    logic [1:0] isel;
    logic [3:0] status;
    logic [3:0] mask;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } apt_state_s;

endpackage

//--- rtl/apt_prescaler.sv
// Prescaler that turns the module clock into single-cycle count ticks.
`timescale 1ns/10ps
module apt_prescaler #(
  parameter int WIDTH = 15
) (
  input wire logic clk,
  input wire logic rstSync_n,
  input wire logic ce,
  input wire logic run,
  input wire logic [2:0] clkSel,
  input wire logic extraDiv,
  output logic tick
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (WIDTH < apt_pkg::PRESC_W) begin : g_bad_width
    $error("prescaler too narrow for the largest divisor");
  end

  logic [WIDTH-1:0] presc_r;
  logic [WIDTH-1:0] presc_nxt;
  logic [WIDTH-1:0] divMask;
  logic [4:0] shift;

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  always_comb begin
    shift = {2'h0, clkSel} + (extraDiv ? 5'h08 : 5'h00);
    divMask = ~({WIDTH{1'b1}} << shift);
    tick = run && ((presc_r & divMask) == divMask);
    presc_nxt = run ? presc_r + {{(WIDTH-1){1'b0}}, 1'b1} : '0;
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      presc_r <= '0;
    end else if (ce) begin
      presc_r <= presc_nxt;
    end
  end

endmodule

//--- rtl/apt_event_unit.sv
// Count-input edge detection and main-timer trigger selection.
`timescale 1ns/10ps
module apt_event_unit (
  input wire logic clk,
  input wire logic rstSync_n,
  input wire logic ce,
  input wire logic externalCountInput,
  input wire logic softCountStrobe,
  input wire logic [1:0] countInputSelect,
  input wire logic [2:0] triggerEventSelect,
  input wire logic [1:0] triggerDirectionSelect,
  input wire logic mainCountDirection,
  input wire logic mainPeriodMatch,
  input wire logic mainZeroMatch,
  input wire logic mainCompareCh0,
  input wire logic mainCompareCh1,
  input wire logic mainCompareCh2,
  input wire logic hallStateChange,
  output logic countEvent,
  output logic trigger
);

  logic extPrev_r;
  logic rise;
  logic fall;
  logic evSel;
  logic dirOk;

  // ----------------------------------------------------------------------
  // Counter-mode events
  // ----------------------------------------------------------------------
  always_comb begin
    rise = externalCountInput && !extPrev_r;
    fall = !externalCountInput && extPrev_r;
    case (apt_pkg::apt_isel_e'(countInputSelect))
      apt_pkg::APT_ISEL_SOFT: countEvent = softCountStrobe;
      apt_pkg::APT_ISEL_RISE: countEvent = rise;
      apt_pkg::APT_ISEL_FALL: countEvent = fall;
      default: countEvent = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Main-timer trigger
  // ----------------------------------------------------------------------
  always_comb begin
    case (apt_pkg::apt_tec_e'(triggerEventSelect))
      apt_pkg::APT_TEC_CH0: evSel = mainCompareCh0;
      apt_pkg::APT_TEC_CH1: evSel = mainCompareCh1;
      apt_pkg::APT_TEC_CH2: evSel = mainCompareCh2;
      apt_pkg::APT_TEC_ANY:
        evSel = mainCompareCh0 || mainCompareCh1 || mainCompareCh2;
      apt_pkg::APT_TEC_PM: evSel = mainPeriodMatch;
      apt_pkg::APT_TEC_ZMUP: evSel = mainZeroMatch && !mainCountDirection;
      apt_pkg::APT_TEC_HALL: evSel = hallStateChange;
      default: evSel = 1'b0;
    endcase
    dirOk = (triggerDirectionSelect[0] && !mainCountDirection) ||
            (triggerDirectionSelect[1] && mainCountDirection);
    trigger = evSel && dirOk;
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      extPrev_r <= 1'b0;
    end else if (ce) begin
      extPrev_r <= externalCountInput;
    end
  end

endmodule

//--- testbench/apt_timer_sva.sv
// Port-level assertions of the auxiliary period timer.
`timescale 1ns/10ps
module apt_timer_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic auxPeriodMatch,
  input wire logic auxZeroMatch,
  input wire logic auxShadowTransfer,
  input wire logic auxRunBit,
  input wire logic [15:0] auxCount
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready;
  endsequence
  property p_wresp;
    s_wr |=> s_axi_bvalid;
  endproperty
  a_wresp: assert property (p_wresp)
    else $error("no write answer");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read answer dropped");
  property p_zero;
    auxZeroMatch == (auxCount == 16'h0000);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");
  property p_wrap;
    auxPeriodMatch |=> $stable(auxCount) || auxCount == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("no return to zero");
  property p_step;
    auxRunBit && !auxPeriodMatch |=> $stable(auxCount) ||
      auxCount == $past(auxCount) + 16'h0001 || auxCount == 16'h0000;
  endproperty
  a_step: assert property (p_step)
    else $error("count step wrong");
  property p_stop;
    !auxRunBit |-> auxShadowTransfer;
  endproperty
  a_stop: assert property (p_stop)
    else $error("no transfer while stopped");
  property p_freeze;
    !ce |=> $stable(auxCount) && $stable(auxRunBit);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved without enable");
endmodule

//--- testbench/apt_main_model.sv
// Model of the main timer and hall logic issuing event pulses.
`timescale 1ns/10ps
module apt_main_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic [2:0] sel,
  input wire logic dirIn,
  output logic dir,
  output logic pm,
  output logic zm,
  output logic [2:0] cmp,
  output logic hall
);
  initial begin
    {dir, pm, zm, cmp, hall} = 7'h00;
  end
  always @(posedge clk) begin
    dir <= dirIn;
    pm <= fire && sel == 3'h5;
    zm <= fire && sel == 3'h6;
    cmp[0] <= fire && sel == 3'h1;
    cmp[1] <= fire && (sel == 3'h2 || sel == 3'h4);
    cmp[2] <= fire && sel == 3'h3;
    hall <= fire && sel == 3'h7;
  end
endmodule

//--- testbench/aux_period_timer_t13_bench.sv
// Self-checking bench of the auxiliary period timer.
`timescale 1ns/10ps
module aux_period_timer_t13_bench;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, extIn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, fire = 1'b0, dirIn = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h00000000, seed = 32'h0000cfe7, rdata;
  logic [2:0] sel = 3'h0, cmp;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic dir, pm, zm, hall, aPm, aZm, aSt, aRun;
  logic [1:0] bresp, rresp;
  logic [15:0] aCnt;
  logic [7:0] sig;
  logic [33:0] expQ[$];
  int fails = 0, n_tests = 0, n, d;
  assign sig = {aZm, aCnt == 16'h0001, ~aRun, aRun, rvalid, arready,
    bvalid, awready};
  always #2.5 clk = ~clk;
  apt_timer i_apt_timer (
    .clk(clk), .rst_n(rst_n), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .externalCountInput(extIn),
    .mainCountDirection(dir), .mainPeriodMatch(pm), .mainZeroMatch(zm),
    .mainCompareCh0(cmp[0]), .mainCompareCh1(cmp[1]),
    .mainCompareCh2(cmp[2]), .hallStateChange(hall),
    .auxPeriodMatch(aPm), .auxZeroMatch(aZm), .auxShadowTransfer(aSt),
    .auxRunBit(aRun), .auxCount(aCnt), .irq(irq)
  );
  apt_main_model i_apt_main_model (
    .clk(clk), .fire(fire), .sel(sel), .dirIn(dirIn), .dir(dir),
    .pm(pm), .zm(zm), .cmp(cmp), .hall(hall)
  );
  // ----------------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string what, logic [33:0] e, logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic waitFor(input int w, output int k);
    k = 0;
    while (sig[w] !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    int k;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    waitFor(0, k);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    waitFor(1, k);
    chk("bresp", a > 6'h17 ? 2'h2 : 2'h0, bresp);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [33:0] e);
    int k;
    expQ.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    waitFor(2, k);
    arvalid <= 1'b0;
    waitFor(3, k);
    rready <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      chk("read", expQ.pop_front(), {rresp, rdata});
    end
  end
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  localparam logic [5:0] CTL = apt_pkg::ADDR_CTRL;
  localparam logic [5:0] ACT = apt_pkg::ADDR_ACTION;
  localparam logic [5:0] CNT = apt_pkg::ADDR_COUNT;
  localparam logic [5:0] PER = apt_pkg::ADDR_PERIOD;
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(CTL, 34'h0);
    rd(apt_pkg::ADDR_MASK, 34'h0);
    rd(6'h18, {apt_pkg::RESP_SLVERR, 32'h0});
    wr(6'h18, 32'h0);
    wr(PER, 32'h3);
    rd(PER, 34'h3);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      d = (i == 2) ? 8 : rnd() % 8;
      wr(CTL, d);
      wr(ACT, 32'h1);
      waitFor(6, n);
      chk("first tick", (1 << d) - 1, n);
      waitFor(7, n);
      chk("period", 3 << d, n);
      wr(ACT, 32'h6);
    end
    $display("test prescaler done");
    wr(CTL, 32'h7);
    wr(ACT, 32'h1);
    wr(PER, 32'h5);
    rd(PER, 34'h3);
    wr(ACT, 32'h8);
    wr(ACT, 32'h10);
    rd(CTL, 34'h10007);
    wr(ACT, 32'h8);
    rd(CTL, 34'h30007);
    waitFor(6, n);
    waitFor(7, n);
    rd(PER, 34'h5);
    rd(CTL, 34'h10007);
    wr(ACT, 32'h2);
    $display("test shadow done");
    wr(CTL, 32'h400);
    wr(CNT, 32'h2);
    rd(CNT, 34'h2);
    wr(ACT, 32'h1);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(ACT, 32'h20);
      rd(CNT, (i + 3) % 6);
    end
    wr(CNT, 32'h7);
    wr(ACT, 32'h20);
    rd(CNT, 34'h1);
    wr(ACT, 32'h4);
    rd(CNT, 34'h0);
    rd(CTL, 34'h10400);
    wr(ACT, 32'h2);
    for (int m = 2; m < 4; m++) begin
      wr(CTL, m << 10);
      wr(ACT, 32'h4);
      wr(ACT, 32'h1);
      repeat (2) begin
        extIn <= 1'b1;
        repeat (3) @(posedge clk);
        extIn <= 1'b0;
        repeat (3) @(posedge clk);
      end
      rd(CNT, 34'h2);
      wr(ACT, 32'h2);
    end
    $display("test counter mode done");
    wr(CNT, 32'h0);
    wr(apt_pkg::ADDR_STATUS, 32'hf);
    for (int i = 0; i < 12; i++) begin
      d = (i < 8) ? i : 5;
      n = (i < 8) ? 3 : i - 8;
      wr(CTL, 32'h13 | (d << 5) | (n << 8));
      dirIn <= i >= 8;
      sel <= d;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (8) @(posedge clk);
      chk("start", (i < 8) ? i != 0 : n >> 1, aRun);
      if (aRun === 1'b1) waitFor(5, n);
      chk("stop", 34'h0, aCnt);
    end
    $display("test trigger done");
    rd(apt_pkg::ADDR_STATUS, 34'hf);
    chk("irq", 34'h0, irq);
    wr(apt_pkg::ADDR_MASK, 32'h8);
    chk("irq", 34'h1, irq);
    wr(apt_pkg::ADDR_STATUS, 32'h8);
    chk("irq", 34'h0, irq);
    rd(apt_pkg::ADDR_STATUS, 34'h7);
    $display("test interrupt done");
    wrap_up();
  end
endmodule
bind apt_timer apt_timer_sva i_apt_timer_sva (
  .clk(clk), .rst_n(rst_n), .ce(ce), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .auxPeriodMatch(auxPeriodMatch),
  .auxZeroMatch(auxZeroMatch), .auxShadowTransfer(auxShadowTransfer),
  .auxRunBit(auxRunBit), .auxCount(auxCount)
);
